// file: rtl/iosd_core.sv
// i/o space access decoder: port, bit, skip, data-space and pointer jump paths
//
// What this block does
// - bit set and clear reach only i/o addresses 0x00 to 0x1F, one bit.
// - skip-next tests one bit set or clear in the low bit-accessible range.
// - a bit set or clear writes only its bit; neighbours stay untouched.
// - some status flags clear when a one is written to their bit.
// - port read and write use i/o addresses 0x00 to 0x3F from the opcode.
// - data-space address of an i/o register is its i/o address plus 0x20.
// - extended i/o 0x60 to 0xFF is reached only by data-space loads and stores.
// - pointer jump loads pc from the pointer pair in 3 cycles, flags unchanged.
`timescale 1ns/1ps
module iosd_core
	import iosd_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic op_valid,
	input wire iosd_op_e op_kind,
	input wire logic [15:0] op_addr,
	input wire logic [5:0] op_disp,
	input wire logic [2:0] op_bit,
	input wire logic [7:0] op_wdata,
	input wire logic [15:0] ptr_z,
	output logic op_ready,
	output logic [7:0] per_addr,
	output logic per_rd,
	output logic per_wr,
	output logic [7:0] per_wdata,
	output logic [7:0] per_wmask,
	input wire logic [7:0] per_rdata,
	output logic res_done,
	output logic res_err,
	output logic [7:0] res_rdata,
	output logic res_skip,
	output logic pc_load,
	output logic [15:0] pc_value
);

	typedef struct packed {
		iosd_state_e state;
		iosd_op_e kind;
		logic [2:0] bit_sel;
		logic legal;
		logic rd_pending;
		logic ready;
		logic [7:0] addr;
		logic rd;
		logic wr;
		logic [7:0] wdata;
		logic [7:0] wmask;
		logic done;
		logic err;
		logic [7:0] rdata;
		logic skip;
		logic pc_ld;
		logic [15:0] pc;
		logic [15:0] ptr;
	} iosd_state_s;

	iosd_state_s s_reg;
	iosd_state_s s_next;

	logic [7:0] map_addr;
	logic map_legal;
	logic map_rd;
	logic map_wr;
	logic [7:0] map_mask;
	logic [7:0] map_byte;
	// one gate per lane keeps the returned bit's path short; the held bit
	// number picks the lane, not the live input, which may already move on
	logic [7:0] lane_sel;
	logic [7:0] lane_one;
	logic bit_is_one;
	logic take;

	genvar gi;
	generate
		for (gi = 0; gi < IOSD_DATA_W; gi++) begin : g_lane
			assign lane_sel[gi] = (s_reg.bit_sel == 3'(gi));
			assign lane_one[gi] = lane_sel[gi] && per_rdata[gi];
		end
	endgenerate

	assign bit_is_one = |lane_one;
	assign take = op_valid && s_reg.ready;

	iosd_addr_map u_map (
		.kind(op_kind),
		.addr(op_addr),
		.disp(op_disp),
		.bit_sel(op_bit),
		.wdata(op_wdata),
		.data_addr(map_addr),
		.legal(map_legal),
		.is_rd(map_rd),
		.is_wr(map_wr),
		.wmask(map_mask),
		.wbyte(map_byte)
	);

	function automatic logic is_skip(input iosd_op_e k);
		is_skip = (k == SKIP_IF_IO_BIT_ONE) || (k == SKIP_IF_IO_BIT_ZERO);
	endfunction

	function automatic logic is_jump(input iosd_op_e k);
		is_jump = (k == POINTER_JUMP_OP);
	endfunction

	// a refused test never skips, so junk on the read bus cannot move the pc
	function automatic logic skip_taken(input iosd_op_e k, input logic ok, input logic one);
		skip_taken = 1'b0;
		if (ok && is_skip(k)) begin
			skip_taken = (k == SKIP_IF_IO_BIT_ONE) ? one : !one;
		end
	endfunction

	// reset image: strobes low, ready high, data fields zero
	function automatic iosd_state_s iosd_rst();
		iosd_state_s r;
		r.state = IOSD_IDLE;
		r.kind = PORT_READ_OP;
		r.bit_sel = 3'h0;
		r.legal = 1'b0;
		r.rd_pending = 1'b0;
		r.ready = 1'b1;
		r.addr = IOSD_RST_BYTE;
		r.rd = 1'b0;
		r.wr = 1'b0;
		r.wdata = IOSD_RST_BYTE;
		r.wmask = IOSD_RST_BYTE;
		r.done = 1'b0;
		r.err = 1'b0;
		r.rdata = IOSD_RST_BYTE;
		r.skip = 1'b0;
		r.pc_ld = 1'b0;
		r.pc = IOSD_RST_PC;
		r.ptr = IOSD_RST_PC;
		iosd_rst = r;
	endfunction

	always_comb begin
		s_next = s_reg;
		// strobes and result pulses last one cycle
		s_next.rd = 1'b0;
		s_next.wr = 1'b0;
		s_next.done = 1'b0;
		s_next.pc_ld = 1'b0;
		case (s_reg.state)
			IOSD_IDLE: begin
				// ready is high only here, so requests are held off while busy
				if (take) begin
					s_next.state = IOSD_ACCESS;
					s_next.ready = 1'b0;
					s_next.kind = op_kind;
					s_next.bit_sel = op_bit;
					s_next.legal = map_legal;
					// target held only for a jump; other ops keep the last one
					if (is_jump(op_kind)) begin
						s_next.ptr = ptr_z;
					end
					// refused accesses raise no strobe, so reserved or
					// out-of-window slots are never touched
					s_next.addr = map_addr;
					s_next.rd = map_legal && map_rd;
					s_next.rd_pending = map_legal && map_rd;
					s_next.wr = map_legal && map_wr;
					s_next.wdata = map_byte;
					s_next.wmask = map_mask;
				end
			end
			IOSD_ACCESS: begin
				// slave answers one cycle after the strobe
				s_next.state = IOSD_CAPTURE;
			end
			IOSD_CAPTURE: begin
				s_next.state = IOSD_IDLE;
				s_next.ready = 1'b1;
				s_next.done = 1'b1;
				s_next.err = !s_reg.legal;
				s_next.skip = skip_taken(s_reg.kind, s_reg.legal, bit_is_one);
				if (s_reg.rd_pending) begin
					s_next.rdata = per_rdata;
				end
				// jump completes on the same schedule; no flag is touched here
				if (is_jump(s_reg.kind)) begin
					s_next.pc_ld = 1'b1;
					s_next.pc = s_reg.ptr;
				end
				s_next.rd_pending = 1'b0;
			end
			default: begin
				s_next.state = IOSD_IDLE;
				s_next.ready = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		// one image for every field, so none is left out of reset
		if (!rstn) begin
			s_reg <= iosd_rst();
		end else begin
			s_reg <= s_next;
		end
	end

	assign op_ready = s_reg.ready;
	assign per_addr = s_reg.addr;
	assign per_rd = s_reg.rd;
	assign per_wr = s_reg.wr;
	assign per_wdata = s_reg.wdata;
	assign per_wmask = s_reg.wmask;
	assign res_done = s_reg.done;
	assign res_err = s_reg.err;
	assign res_rdata = s_reg.rdata;
	assign res_skip = s_reg.skip;
	assign pc_load = s_reg.pc_ld;
	assign pc_value = s_reg.pc;

endmodule // iosd_core

// file: rtl/iosd_pkg.sv
// constants, operation codes and state type for the i/o access decoder
package iosd_pkg;

	// i/o address windows (i/o numbering, except extended i/o, which uses data-space numbering)
	localparam logic [7:0] IOSD_BIT_IO_FIRST = 8'h00;
	localparam logic [7:0] IOSD_BIT_IO_LAST = 8'h1F;
	localparam logic [7:0] IOSD_PORT_IO_FIRST = 8'h00;
	localparam logic [7:0] IOSD_PORT_IO_LAST = 8'h3F;
	localparam logic [7:0] IOSD_IO_DATA_OFFSET = 8'h20;
	localparam logic [7:0] IOSD_EXT_IO_FIRST = 8'h60;
	localparam logic [7:0] IOSD_EXT_IO_LAST = 8'hFF;
	localparam int IOSD_PORT_COUNT = 64;

	// data-space window this block serves: i/o plus extended i/o
	localparam logic [15:0] IOSD_DATA_FIRST = 16'h0020;
	localparam logic [15:0] IOSD_DATA_LAST = 16'h00FF;

	// field widths and positions
	localparam int IOSD_DATA_W = 8;
	localparam int IOSD_PC_W = 16;
	localparam int IOSD_BITSEL_W = 3;
	localparam int IOSD_DISP_W = 6;

	// cycles with ready low between acceptance and completion for every operation
	localparam int IOSD_OP_CYCLES = 2;

	// reset values
	localparam logic [7:0] IOSD_RST_BYTE = 8'h00;
	localparam logic [15:0] IOSD_RST_PC = 16'h0000;

	typedef enum logic [3:0] {
		PORT_READ_OP,
		PORT_WRITE_OP,
		IO_BIT_SET_OP,
		IO_BIT_CLEAR_OP,
		SKIP_IF_IO_BIT_ONE,
		SKIP_IF_IO_BIT_ZERO,
		MEMORY_READ_OP,
		DIRECT_MEMORY_READ,
		DISPLACED_MEMORY_READ,
		MEMORY_WRITE_OP,
		DIRECT_MEMORY_WRITE,
		DISPLACED_MEMORY_WRITE,
		POINTER_JUMP_OP
	} iosd_op_e;

	typedef enum logic [1:0] {
		IOSD_IDLE,
		IOSD_ACCESS,
		IOSD_CAPTURE
	} iosd_state_e;

endpackage

// file: rtl/iosd_addr_map.sv
// address mapping, legality check and write mask for one operation
`timescale 1ns/1ps
module iosd_addr_map
	import iosd_pkg::*;
(
	input wire iosd_op_e kind,
	input wire logic [15:0] addr,
	input wire logic [5:0] disp,
	input wire logic [2:0] bit_sel,
	input wire logic [7:0] wdata,
	output logic [7:0] data_addr,
	output logic legal,
	output logic is_rd,
	output logic is_wr,
	output logic [7:0] wmask,
	output logic [7:0] wbyte
);

	function automatic logic [7:0] iosd_onehot(input logic [2:0] b);
		iosd_onehot = 8'h01 << b;
	endfunction

	function automatic logic in_data_window(input logic [15:0] a);
		in_data_window = (a >= IOSD_DATA_FIRST) && (a <= IOSD_DATA_LAST);
	endfunction

	logic [15:0] eff_addr;
	logic [7:0] io_plus;

	always_comb begin
		eff_addr = addr;
		io_plus = addr[7:0] + IOSD_IO_DATA_OFFSET;
		data_addr = io_plus;
		legal = 1'b0;
		is_rd = 1'b0;
		is_wr = 1'b0;
		wmask = 8'hFF;
		wbyte = wdata;
		case (kind)
			PORT_READ_OP, PORT_WRITE_OP: begin
				// 64 port slots only; extended i/o never reached here
				legal = (addr[15:8] == 8'h00) && (addr[7:0] <= IOSD_PORT_IO_LAST);
				is_rd = (kind == PORT_READ_OP);
				is_wr = (kind == PORT_WRITE_OP);
			end
			IO_BIT_SET_OP, IO_BIT_CLEAR_OP: begin
				legal = (addr[15:8] == 8'h00) && (addr[7:0] <= IOSD_BIT_IO_LAST);
				is_wr = 1'b1;
				// only the named lane is enabled, so w1c flags beside it stay
				wmask = iosd_onehot(bit_sel);
				// a set writes one in that lane, clearing a w1c flag there
				wbyte = (kind == IO_BIT_SET_OP) ? iosd_onehot(bit_sel) : 8'h00;
			end
			SKIP_IF_IO_BIT_ONE, SKIP_IF_IO_BIT_ZERO: begin
				legal = (addr[15:8] == 8'h00) && (addr[7:0] <= IOSD_BIT_IO_LAST);
				is_rd = 1'b1;
			end
			MEMORY_READ_OP, DIRECT_MEMORY_READ, MEMORY_WRITE_OP, DIRECT_MEMORY_WRITE,
			DISPLACED_MEMORY_READ, DISPLACED_MEMORY_WRITE: begin
				if (kind == DISPLACED_MEMORY_READ || kind == DISPLACED_MEMORY_WRITE) begin
					eff_addr = addr + {10'h000, disp};
				end
				// data-space path covers both i/o and extended i/o
				data_addr = eff_addr[7:0];
				legal = in_data_window(eff_addr);
				is_rd = (kind == MEMORY_READ_OP) || (kind == DIRECT_MEMORY_READ) ||
					(kind == DISPLACED_MEMORY_READ);
				is_wr = !is_rd;
			end
			POINTER_JUMP_OP: begin
				legal = 1'b1;
			end
			default: begin
				legal = 1'b0;
			end
		endcase
	end

endmodule // iosd_addr_map

// file: dv/iosd_slave.sv
// peripheral register slave model for the i/o access decoder
`timescale 1ns/1ps
module iosd_slave
	import iosd_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [7:0] per_addr,
	input wire logic per_rd,
	input wire logic per_wr,
	input wire logic [7:0] per_wdata,
	input wire logic [7:0] per_wmask,
	output logic [7:0] per_rdata
);
	logic [7:0] mem [256];
	logic [7:0] hit;
	assign hit = per_wdata & per_wmask;
	always_ff @(posedge clk) begin
		if (!rstn) begin
			for (int i = 0; i < 256; i++) begin
				mem[i] <= 8'h00;
			end
			// flag pending at 0x25 so a w1c clear can be seen
			mem[37] <= 8'h01;
			per_rdata <= 8'h00;
		end else begin
			// bit 0 of every register is w1c; only enabled lanes change
			if (per_wr) begin
				mem[per_addr] <= (mem[per_addr] & ~per_wmask & 8'hFE) | (hit & 8'hFE)
					| (mem[per_addr] & ~hit & 8'h01);
			end
			// data only in the cycle after the strobe, junk otherwise
			if (per_rd) begin
				per_rdata <= mem[per_addr];
			end else begin
				per_rdata <= ~per_rdata;
			end
		end
	end
endmodule // iosd_slave

// file: dv/iosd_core_sva.sv
// port assertions for the i/o access decoder
`timescale 1ns/1ps
module iosd_core_sva
	import iosd_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic op_valid,
	input wire logic op_ready,
	input wire iosd_op_e op_kind,
	input wire logic [15:0] op_addr,
	input wire logic [2:0] op_bit,
	input wire logic [15:0] ptr_z,
	input wire logic [7:0] per_addr,
	input wire logic per_rd,
	input wire logic per_wr,
	input wire logic [7:0] per_wmask,
	input wire logic [7:0] per_rdata,
	input wire logic res_done,
	input wire logic res_err,
	input wire logic res_skip,
	input wire logic pc_load,
	input wire logic [15:0] pc_value
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	logic [2:0] bq;
	logic bitop;
	logic portop;
	assign bitop = op_kind == IO_BIT_SET_OP || op_kind == IO_BIT_CLEAR_OP;
	assign portop = op_kind == PORT_READ_OP || op_kind == PORT_WRITE_OP;
	// bit number kept, the input may move on after the take
	always_ff @(posedge clk) begin
		if (op_valid && op_ready) begin
			bq <= op_bit;
		end
	end
	sequence s_take;
		op_valid && op_ready;
	endsequence
	sequence s_busy;
		!op_ready [*2] ##1 op_ready && res_done;
	endsequence
	property p_sched;
		s_take |=> s_busy;
	endproperty
	a_sched: assert property (p_sched) else $error("bad busy schedule");
	property p_jump;
		s_take ##0 op_kind == POINTER_JUMP_OP |-> ##3 pc_load && pc_value == $past(ptr_z, 3);
	endproperty
	a_jump: assert property (p_jump) else $error("bad jump");
	property p_pc_pulse;
		pc_load |-> res_done ##1 !pc_load;
	endproperty
	a_pc_pulse: assert property (p_pc_pulse) else $error("bad pc pulse");
	property p_bit_lane;
		s_take ##0 bitop && op_addr <= 16'h001F |=> per_wr
			&& per_wmask == 8'h01 << $past(op_bit) && per_addr == $past(op_addr[7:0]) + 8'h20;
	endproperty
	a_bit_lane: assert property (p_bit_lane) else $error("bad bit lane");
	property p_bit_refuse;
		s_take ##0 bitop && op_addr > 16'h001F |=> !per_wr ##1 1'b1 ##1 res_err;
	endproperty
	a_bit_refuse: assert property (p_bit_refuse) else $error("bit op not refused");
	property p_port_map;
		s_take ##0 portop && op_addr <= 16'h003F |=> (per_rd || per_wr)
			&& per_addr == $past(op_addr[7:0]) + 8'h20;
	endproperty
	a_port_map: assert property (p_port_map) else $error("bad port address");
	property p_port_refuse;
		s_take ##0 portop && op_addr > 16'h003F |-> ##3 res_err && !res_skip;
	endproperty
	a_port_refuse: assert property (p_port_refuse) else $error("port not refused");
	property p_skip_one;
		s_take ##0 op_kind == SKIP_IF_IO_BIT_ONE && op_addr <= 16'h001F
			|-> ##3 res_skip == $past(per_rdata[bq]);
	endproperty
	a_skip_one: assert property (p_skip_one) else $error("bad skip on one");
	property p_skip_zero;
		s_take ##0 op_kind == SKIP_IF_IO_BIT_ZERO && op_addr <= 16'h001F
			|-> ##3 res_skip == !$past(per_rdata[bq]);
	endproperty
	a_skip_zero: assert property (p_skip_zero) else $error("bad skip on zero");
	property p_ext;
		s_take ##0 (op_kind == DIRECT_MEMORY_READ || op_kind == MEMORY_READ_OP)
			&& op_addr >= 16'h0060 && op_addr <= 16'h00FF
			|=> per_rd && per_addr == $past(op_addr[7:0]);
	endproperty
	a_ext: assert property (p_ext) else $error("bad extended read");
endmodule // iosd_core_sva
bind iosd_core iosd_core_sva chk_i (.clk, .rstn, .op_valid, .op_ready, .op_kind, .op_addr,
	.op_bit, .ptr_z, .per_addr, .per_rd, .per_wr, .per_wmask, .per_rdata, .res_done, .res_err,
	.res_skip, .pc_load, .pc_value);

// file: dv/testbench.sv
// self-checking bench for the i/o access decoder
`timescale 1ns/1ps
module testbench;
	import iosd_pkg::*;
	logic clk, rstn, op_valid, op_ready, per_rd, per_wr, res_done, res_err, res_skip, pc_load;
	iosd_op_e op_kind;
	logic [15:0] op_addr, ptr_z, pc_value;
	logic [5:0] op_disp;
	logic [2:0] op_bit;
	logic [7:0] op_wdata, per_addr, per_wdata, per_wmask, per_rdata, res_rdata;
	logic [7:0] s_addr, s_mask, s_data;
	logic s_str;
	int fails = 0, num_checks = 0, cyc = 0, lat;
	iosd_core dut (.clk, .rstn, .op_valid, .op_kind, .op_addr, .op_disp, .op_bit, .op_wdata,
		.ptr_z, .op_ready, .per_addr, .per_rd, .per_wr, .per_wdata, .per_wmask, .per_rdata,
		.res_done, .res_err, .res_rdata, .res_skip, .pc_load, .pc_value);
	iosd_slave slv (.clk, .rstn, .per_addr, .per_rd, .per_wr, .per_wdata, .per_wmask,
		.per_rdata);
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 400) begin
			fails++;
			close_out();
		end
	end
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic op(input iosd_op_e k, input logic [15:0] a, input logic [5:0] d,
		input logic [2:0] b, input logic [7:0] w);
		@(posedge clk);
		op_valid <= 1'b1;
		op_kind <= k;
		op_addr <= a;
		op_disp <= d;
		op_bit <= b;
		op_wdata <= w;
		@(posedge clk);
		op_valid <= 1'b0;
		#1;
		s_str = per_rd | per_wr;
		s_addr = per_addr;
		s_mask = per_wmask;
		s_data = per_wdata;
		lat = 1;
		while (res_done !== 1'b1 && lat < 6) begin
			@(posedge clk);
			#1;
			lat++;
		end
		chk(24'(lat), 24'h3);
	endtask
	task automatic t_bit();
		op(IO_BIT_SET_OP, 16'h0005, 6'h00, 3'h3, 8'h00);
		chk({s_addr, s_mask, s_data}, 24'h250808);
		op(DIRECT_MEMORY_READ, 16'h0025, 6'h00, 3'h0, 8'h00);
		chk(24'(res_rdata), 24'h09);
		op(IO_BIT_SET_OP, 16'h0005, 6'h00, 3'h0, 8'h00);
		op(PORT_READ_OP, 16'h0005, 6'h00, 3'h0, 8'h00);
		chk(24'(res_rdata), 24'h08);
		op(IO_BIT_CLEAR_OP, 16'h0005, 6'h00, 3'h3, 8'h00);
		chk({s_addr, s_mask, s_data}, 24'h250800);
		op(IO_BIT_CLEAR_OP, 16'h0020, 6'h00, 3'h3, 8'h00);
		chk(24'({s_str, res_err}), 24'h1);
	endtask
	task automatic t_skip();
		op(IO_BIT_SET_OP, 16'h0005, 6'h00, 3'h6, 8'h00);
		op(SKIP_IF_IO_BIT_ONE, 16'h0005, 6'h00, 3'h6, 8'h00);
		chk(24'({res_err, res_skip}), 24'h1);
		op(SKIP_IF_IO_BIT_ZERO, 16'h0005, 6'h00, 3'h6, 8'h00);
		chk(24'({res_err, res_skip}), 24'h0);
		op(SKIP_IF_IO_BIT_ZERO, 16'h0005, 6'h00, 3'h2, 8'h00);
		chk(24'({res_err, res_skip}), 24'h1);
		op(SKIP_IF_IO_BIT_ONE, 16'h0020, 6'h00, 3'h6, 8'h00);
		chk(24'({res_err, res_skip}), 24'h2);
	endtask
	// writes land on mapped registers only
	task automatic t_port();
		op(PORT_WRITE_OP, 16'h003F, 6'h00, 3'h0, 8'hA4);
		chk({s_addr, s_mask, s_data}, 24'h5FFFA4);
		op(DISPLACED_MEMORY_READ, 16'h0059, 6'h06, 3'h0, 8'h00);
		chk(24'({res_err, res_rdata}), 24'h0000A4);
		op(PORT_READ_OP, 16'h0040, 6'h00, 3'h0, 8'h00);
		chk(24'({s_str, res_err}), 24'h1);
		op(DISPLACED_MEMORY_WRITE, 16'h00C0, 6'h06, 3'h0, 8'h3C);
		chk({s_addr, s_mask, s_data}, 24'hC6FF3C);
		op(DIRECT_MEMORY_WRITE, 16'h0060, 6'h00, 3'h0, 8'h5A);
		op(MEMORY_READ_OP, 16'h0060, 6'h00, 3'h0, 8'h00);
		chk(24'(res_rdata), 24'h5A);
		op(MEMORY_WRITE_OP, 16'h0100, 6'h00, 3'h0, 8'h00);
		chk(24'({s_str, res_err}), 24'h1);
	endtask
	task automatic t_jump();
		@(posedge clk);
		ptr_z <= 16'hBEEF;
		op(POINTER_JUMP_OP, 16'h0000, 6'h00, 3'h0, 8'h00);
		chk({7'h00, pc_load, pc_value}, 24'h01BEEF);
		chk(24'(s_str), 24'h0);
	endtask
	initial begin
		rstn = 1'b0;
		op_valid = 1'b0;
		op_kind = PORT_READ_OP;
		op_addr = 16'h0000;
		op_disp = 6'h00;
		op_bit = 3'h0;
		op_wdata = 8'h00;
		ptr_z = 16'h0000;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		t_bit();
		t_skip();
		t_port();
		t_jump();
		close_out();
	end
endmodule // testbench
